// ### logic/adc_queue2_scan_mode.sv
// queue-two scan mode control: trigger selection, interval timer, suspend/resume and register slave
//
// Summary of operation
// R1: mode 00000 disables queue two, no conversions
// R2: 00001 software single scan, started by enable bit
// R3: 00010/00011 single scan on rising/falling trigger edge
// R4: 00100-01110 interval timer single scan, 2^7..2^17 clocks
// R5: 10001 software continuous scan, started by enable bit
// R6: 10010/10011 continuous scan on rising/falling edges
// R7: 10100-11110 periodic timer continuous scan, 2^7..2^17
// R8: resume bit 0 restarts at first command word
// R9: resume bit 1 resumes at aborted command word
// R10: resume change applies at end-of-queue or mode change
// R11: reserved codes 01111, 10000, 11111 act disabled
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module adc_queue2_scan_mode
   import q2_pkg::*;
#(
   parameter int CONV_DIV = q2_pkg::CONV_DIV_DEF
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic queue2_external_trigger_pin,
   input wire logic end_of_queue,
   input wire logic q1_suspend,
   input wire logic q1_release,
   output q2_pkg::seq_cmd_s seq_cmd,
   output logic scan_active,
   output logic converter_clock,
   input wire logic [q2_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [q2_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [q2_pkg::STRB_W-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [q2_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [q2_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import q2_pkg::*;

   // word match of a byte address against a register offset
   function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
      is_reg = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
   endfunction

   // split a mode code into trigger kind, scan form and timer exponent
   function automatic mode_dec_s decode_mode(input logic [MODE_W-1:0] m);
      logic [3:0] lo;
      mode_dec_s d;
      lo = m[3:0];
      d.kind = K_OFF;
      d.cont = m[CONT_BIT];
      d.expo = 5'h00;
      if (lo == LO_SW) begin
         d.kind = K_SW;
      end else if (lo == LO_RISE) begin
         d.kind = K_RISE;
      end else if (lo == LO_FALL) begin
         d.kind = K_FALL;
      end else if (lo >= LO_TMR_FIRST && lo <= LO_TMR_LAST) begin
         d.kind = K_TIMER;
         d.expo = {1'b0, lo} + EXP_OFS;
      end
      decode_mode = d;
   endfunction

   // low-bit mask whose all-ones value marks the end of an interval
   function automatic logic [TMR_W-1:0] period_mask(input logic [4:0] e);
      period_mask = TMR_W'((TMR_W+1)'(1) << e) - TMR_W'(1);
   endfunction

   logic [MODE_W-1:0] mode_r;
   logic res_r;
   logic sse_r;
   logic eff_res_r;
   scan_state_e state_r;
   seq_cmd_s cmd_r;
   logic active_r;
   logic trig_prev_r;
   logic [$clog2(CONV_DIV+1)-1:0] div_r;
   logic converter_clock_r;
   logic [TMR_W-1:0] tmr_r;
   logic aw_have_r;
   logic [ADDR_W-1:0] aw_addr_r;
   logic w_have_r;
   logic [DATA_W-1:0] w_data_r;
   logic [STRB_W-1:0] w_strb_r;
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic arready_r;
   logic rvalid_r;
   logic [DATA_W-1:0] rdata_r;
   logic [1:0] rresp_r;
   mode_dec_s dec;
   logic wr_commit;
   logic wr_ctrl;
   logic mode_wr;
   logic [MODE_W-1:0] mode_nxt;
   logic mode_chg;
   logic rise_edge;
   logic fall_edge;
   logic converter_clock_tick;
   logic tmr_hit;
   logic eoq_scan;
   logic trig;
   logic start_go;
   logic [DATA_W-1:0] rdata_nxt;

   assign dec = decode_mode(mode_r);

   // outputs straight from flip-flops
   assign seq_cmd = cmd_r;
   assign scan_active = active_r;
   assign converter_clock = converter_clock_r;
   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // write address and data are caught independently, committed together
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         aw_have_r <= 1'b0;
         aw_addr_r <= '0;
         awready_r <= 1'b1;
      end else if (s_axi_awvalid && awready_r) begin
         aw_have_r <= 1'b1;
         aw_addr_r <= s_axi_awaddr;
         awready_r <= 1'b0;
      end else if (bvalid_r && s_axi_bready) begin
         aw_have_r <= 1'b0;
         awready_r <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         w_have_r <= 1'b0;
         w_data_r <= '0;
         w_strb_r <= '0;
         wready_r <= 1'b1;
      end else if (s_axi_wvalid && wready_r) begin
         w_have_r <= 1'b1;
         w_data_r <= s_axi_wdata;
         w_strb_r <= s_axi_wstrb;
         wready_r <= 1'b0;
      end else if (bvalid_r && s_axi_bready) begin
         w_have_r <= 1'b0;
         wready_r <= 1'b1;
      end
   end

   // write commit and its decode
   assign wr_commit = aw_have_r && w_have_r && !bvalid_r;
   assign wr_ctrl = wr_commit && is_reg(aw_addr_r, CTRL_OFS);
   assign mode_wr = wr_ctrl && w_strb_r[MODE_BYTE];
   assign mode_nxt = w_data_r[MODE_LSB +: MODE_W];
   assign mode_chg = mode_wr && (mode_nxt != mode_r);

   // write response; the status register is read-only
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (wr_commit) begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_ctrl ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // read data mux
   always_comb begin
      rdata_nxt = '0;
      if (is_reg(s_axi_araddr, CTRL_OFS)) begin
         rdata_nxt[MODE_LSB +: MODE_W] = mode_r;
         rdata_nxt[RES_BIT] = res_r;
         rdata_nxt[SSE_BIT] = sse_r;
      end else if (is_reg(s_axi_araddr, STAT_OFS)) begin
         rdata_nxt[ST_ACTIVE_BIT] = active_r;
         rdata_nxt[ST_SUSP_BIT] = (state_r == ST_SUSP);
         rdata_nxt[ST_EFFRES_BIT] = eff_res_r;
         rdata_nxt[ST_SSE_BIT] = sse_r;
         rdata_nxt[ST_MODE_LSB +: MODE_W] = mode_r;
      end
   end

   // read channel: one read in flight, unmapped reads answer zero with an error
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
      end else if (s_axi_arvalid && arready_r) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= rdata_nxt;
         rresp_r <= (is_reg(s_axi_araddr, CTRL_OFS) || is_reg(s_axi_araddr, STAT_OFS)) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
      end
   end

   // mode and resume select fields
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mode_r <= MODE_RST;
         res_r <= RES_RST;
      end else begin
         if (mode_wr) begin
            mode_r <= mode_nxt;
         end
         if (wr_ctrl && w_strb_r[FLAG_BYTE]) begin
            res_r <= w_data_r[RES_BIT];
         end
      end
   end

   // single-scan enable: a software write of one wins over the end-of-scan clear
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sse_r <= SSE_RST;
      end else if (wr_ctrl && w_strb_r[FLAG_BYTE]) begin
         sse_r <= w_data_r[SSE_BIT];
      end else if (eoq_scan && !dec.cont) begin
         sse_r <= 1'b0; // R2
      end
   end

   // resume point latched only while idle, at end of queue or on a mode change
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         eff_res_r <= RES_RST;
      end else if (state_r == ST_IDLE || eoq_scan || mode_chg) begin
         eff_res_r <= res_r; // R10
      end
   end

   // converter clock: one-cycle enable every CONV_DIV system clocks
   assign converter_clock_tick = (div_r == ($bits(div_r))'(CONV_DIV - 1));
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         div_r <= '0;
         converter_clock_r <= 1'b0;
      end else begin
         div_r <= converter_clock_tick ? '0 : div_r + 1'b1;
         converter_clock_r <= converter_clock_tick;
      end
   end

   // interval timer counts converter clocks, restarted by a mode change
   assign tmr_hit = converter_clock_tick && dec.kind == K_TIMER && (tmr_r & period_mask(dec.expo)) == period_mask(dec.expo);
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         tmr_r <= '0;
      end else if (mode_chg || dec.kind != K_TIMER) begin
         tmr_r <= '0;
      end else if (converter_clock_tick) begin
         tmr_r <= tmr_r + 1'b1; // R4 R7
      end
   end

   // trigger pin edge detect
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         trig_prev_r <= 1'b0;
      end else begin
         trig_prev_r <= queue2_external_trigger_pin;
      end
   end
   assign rise_edge = queue2_external_trigger_pin && !trig_prev_r;
   assign fall_edge = !queue2_external_trigger_pin && trig_prev_r;

   // trigger selection; single-scan forms need the enable bit armed
   always_comb begin
      trig = 1'b0;
      unique case (dec.kind)
         K_OFF: trig = 1'b0; // R1 R11
         K_SW: trig = sse_r; // R2 R5
         K_RISE: trig = rise_edge && (dec.cont || sse_r); // R3 R6
         K_FALL: trig = fall_edge && (dec.cont || sse_r); // R3 R6
         K_TIMER: trig = tmr_hit && (dec.cont || sse_r); // R4 R7
      endcase
   end
   assign eoq_scan = (state_r == ST_SCAN) && end_of_queue;
   assign start_go = (state_r == ST_IDLE) && trig && !mode_chg;

   // scan sequencing, suspension by queue one and resumption
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         cmd_r <= '0;
         active_r <= 1'b0;
      end else begin
         cmd_r <= '0;
         if (mode_chg) begin
            state_r <= ST_IDLE;
            active_r <= 1'b0;
         end else begin
            unique case (state_r)
               ST_IDLE: begin
                  if (start_go) begin
                     state_r <= ST_SCAN;
                     active_r <= 1'b1;
                     cmd_r.start <= 1'b1;
                  end
               end
               ST_SCAN: begin
                  if (end_of_queue) begin
                     state_r <= ST_IDLE;
                     active_r <= 1'b0;
                  end else if (q1_suspend) begin
                     state_r <= ST_SUSP;
                  end
               end
               ST_SUSP: begin
                  if (q1_release) begin
                     state_r <= ST_SCAN;
                     cmd_r.resume <= 1'b1;
                     cmd_r.from_aborted <= eff_res_r; // R8 R9
                  end
               end
            endcase
         end
      end
   end

   // named steps of a scan
   sequence s_idle_armed;
      state_r == ST_IDLE && !mode_chg;
   endsequence
   sequence s_started;
      cmd_r.start && state_r == ST_SCAN;
   endsequence
   sequence s_cont_sw_end;
      eoq_scan && !mode_chg && dec.kind == K_SW && dec.cont && sse_r && !(wr_ctrl && w_strb_r[FLAG_BYTE]);
   endsequence

   a_off_no_scan: assert property (@(posedge sys_clk) disable iff (!rst_n) // R1
      mode_r == MODE_RST |=> !cmd_r.start)
      else $error("scan started while queue two disabled");
   a_sw_single_start: assert property (@(posedge sys_clk) disable iff (!rst_n) // R2
      s_idle_armed and (dec.kind == K_SW && !dec.cont && sse_r) |=> s_started)
      else $error("software single scan did not start");
   a_edge_single_start: assert property (@(posedge sys_clk) disable iff (!rst_n) // R3
      s_idle_armed and (!dec.cont && sse_r && ((dec.kind == K_RISE && rise_edge) || (dec.kind == K_FALL && fall_edge)))
      |=> s_started)
      else $error("trigger edge did not start a single scan");
   a_tmr_single_start: assert property (@(posedge sys_clk) disable iff (!rst_n) // R4
      s_idle_armed and (dec.kind == K_TIMER && !dec.cont && sse_r && tmr_hit) |=> s_started)
      else $error("interval timer did not start a single scan");
   a_tmr_period_len: assert property (@(posedge sys_clk) disable iff (!rst_n) // R4
      tmr_hit |-> ((tmr_r + 1'b1) & period_mask(dec.expo)) == '0 && dec.expo >= 5'h07 && dec.expo <= 5'h11)
      else $error("timer interval does not match the selected power of two");
   a_sw_cont_restart: assert property (@(posedge sys_clk) disable iff (!rst_n) // R5
      s_cont_sw_end ##1 !mode_chg |=> s_started)
      else $error("software continuous scan did not restart");
   a_edge_cont_start: assert property (@(posedge sys_clk) disable iff (!rst_n) // R6
      s_idle_armed and (dec.cont && ((dec.kind == K_RISE && rise_edge) || (dec.kind == K_FALL && fall_edge)))
      |=> s_started)
      else $error("trigger edge did not start a continuous scan");
   a_tmr_cont_start: assert property (@(posedge sys_clk) disable iff (!rst_n) // R7
      s_idle_armed and (dec.kind == K_TIMER && dec.cont && tmr_hit) |=> s_started)
      else $error("periodic timer did not start a scan");
   a_resume_first: assert property (@(posedge sys_clk) disable iff (!rst_n) // R8
      state_r == ST_SUSP && q1_release && !mode_chg && !eff_res_r |=> cmd_r.resume && !cmd_r.from_aborted)
      else $error("resume did not restart at the first command word");
   a_resume_abort: assert property (@(posedge sys_clk) disable iff (!rst_n) // R9
      state_r == ST_SUSP && q1_release && !mode_chg && eff_res_r |=> cmd_r.resume && cmd_r.from_aborted)
      else $error("resume did not return to the aborted command word");
   a_res_held: assert property (@(posedge sys_clk) disable iff (!rst_n) // R10
      state_r != ST_IDLE && !eoq_scan && !mode_chg |=> $stable(eff_res_r))
      else $error("resume point changed during queue execution");
   a_reserved_idle: assert property (@(posedge sys_clk) disable iff (!rst_n) // R11
      mode_r[3:0] == 4'hF || mode_r == 5'h10 |=> !cmd_r.start)
      else $error("scan started in a reserved mode");
endmodule
`default_nettype wire

// ### logic/q2_pkg.sv
// constants, types and register map for the queue-two scan mode control block
package q2_pkg;
   // register bus geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int STRB_W = DATA_W / 8;
   localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
   localparam logic [ADDR_W-1:0] STAT_OFS = 4'h4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // control register fields
   localparam int MODE_LSB = 0;
   localparam int MODE_W = 5;
   localparam int RES_BIT = 8;
   localparam int SSE_BIT = 9;
   localparam int MODE_BYTE = 0;
   localparam int FLAG_BYTE = 1;
   localparam logic [MODE_W-1:0] MODE_RST = 5'h00;
   localparam logic RES_RST = 1'h0;
   localparam logic SSE_RST = 1'h0;
   // status register fields
   localparam int ST_ACTIVE_BIT = 0;
   localparam int ST_SUSP_BIT = 1;
   localparam int ST_EFFRES_BIT = 2;
   localparam int ST_SSE_BIT = 3;
   localparam int ST_MODE_LSB = 8;
   // mode code layout: top bit picks continuous scan, low nibble the trigger
   localparam int CONT_BIT = 4;
   localparam logic [3:0] LO_SW = 4'h1;
   localparam logic [3:0] LO_RISE = 4'h2;
   localparam logic [3:0] LO_FALL = 4'h3;
   localparam logic [3:0] LO_TMR_FIRST = 4'h4;
   localparam logic [3:0] LO_TMR_LAST = 4'hE;
   localparam logic [4:0] EXP_OFS = 5'h03;
   // interval timer width covers the longest interval of 2^17 converter clocks
   localparam int TMR_W = 17;
   localparam int CONV_DIV_DEF = 4;
   typedef enum logic [2:0] {K_OFF, K_SW, K_RISE, K_FALL, K_TIMER} trig_kind_e;
   typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_SUSP} scan_state_e;
   typedef struct packed {
      trig_kind_e kind;
      logic cont;
      logic [4:0] expo;
   } mode_dec_s;
   typedef struct packed {
      logic start;
      logic resume;
      logic from_aborted;
   } seq_cmd_s;
endpackage

// ### tb/seq_model.sv
// behavioural sequencer and queue-one model facing the queue-two scan control
`timescale 1ns/1ps
`default_nettype none
module seq_model
   import q2_pkg::*;
#(
   parameter int SCAN_LEN = 24,
   parameter int SUSP_AT = 10
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire q2_pkg::seq_cmd_s seq_cmd,
   input wire logic scan_active,
   input wire logic susp_en,
   output logic end_of_queue,
   output logic q1_suspend,
   output logic q1_release
);
   int cnt;
   int hold;
   logic busy;
   logic susp;
   // one scan lasts SCAN_LEN+1 cycles; queue one may cut in once and release four cycles later
   always_ff @(posedge sys_clk) begin
      end_of_queue <= 1'b0;
      q1_suspend <= 1'b0;
      q1_release <= 1'b0;
      if (!rst_n) begin
         busy <= 1'b0;
         susp <= 1'b0;
         cnt <= 0;
         hold <= 0;
      end else if (seq_cmd.start) begin
         busy <= 1'b1;
         cnt <= 0;
      end else if (busy && !scan_active) begin
         busy <= 1'b0; // scan aborted by a mode change
         susp <= 1'b0;
      end else if (susp) begin
         hold <= hold + 1;
         if (hold == 3) begin
            q1_release <= 1'b1;
            susp <= 1'b0;
         end
      end else if (busy) begin
         cnt <= cnt + 1;
         if (susp_en && cnt == SUSP_AT) begin
            q1_suspend <= 1'b1;
            susp <= 1'b1;
            hold <= 0;
         end else if (cnt == SCAN_LEN) begin
            end_of_queue <= 1'b1;
            busy <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the queue-two scan mode control
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import q2_pkg::*;
   logic sys_clk, rst_n, queue2_external_trigger_pin, susp_en, last_from_aborted;
   logic end_of_queue, q1_suspend, q1_release, scan_active, converter_clock;
   seq_cmd_s seq_cmd;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
   logic [STRB_W-1:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] d;
   logic [4:0] m;
   logic [4:0] off_codes [4] = '{5'h00, 5'h0F, 5'h10, 5'h1F};
   logic [4:0] edge_codes [4] = '{5'h02, 5'h03, 5'h12, 5'h13};
   logic [4:0] tmr_codes [3] = '{5'h04, 5'h05, 5'h14};
   int num_errors = 0, n_compared = 0, start_count = 0, resume_count = 0, cycles = 0, c0;

   adc_queue2_scan_mode #(.CONV_DIV(1)) i_adc_queue2_scan_mode (
      .sys_clk, .rst_n, .queue2_external_trigger_pin, .end_of_queue, .q1_suspend, .q1_release,
      .seq_cmd, .scan_active, .converter_clock, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);

   seq_model i_seq_model (.sys_clk, .rst_n, .seq_cmd, .scan_active, .susp_en, .end_of_queue,
      .q1_suspend, .q1_release);

   // clock at 25 MHz
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // count command pulses and cut a hang short
   always @(posedge sys_clk) begin
      cycles++;
      if (seq_cmd.start === 1'b1) start_count++;
      if (seq_cmd.resume === 1'b1) begin
         resume_count++;
         last_from_aborted = seq_cmd.from_aborted;
      end
      if (cycles == 30000) begin
         num_errors++;
         $display("timeout after %0d cycles", cycles);
         give_verdict();
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // axi write: address and data offered together, each dropped when taken
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask

   task automatic ctrl(input logic [4:0] mode, input logic res, input logic en);
      wr(CTRL_OFS, {22'h0, en, res, 3'h0, mode});
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      rst_n = 1'b0;
      queue2_external_trigger_pin = 1'b0;
      susp_en = 1'b0;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_awaddr = '0;
      s_axi_araddr = '0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'hF;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      idle(20);
      rst_n <= 1'b1;
      idle(1);
      // reset values, read-only status, unmapped place
      rd(CTRL_OFS);
      check("ctrl reset", d, 32'h0000_0000);
      check("converter clock", 32'(converter_clock), 32'h1);
      rd(STAT_OFS);
      check("status reset", d, 32'h0000_0000);
      wr(STAT_OFS, 32'hFFFF_FFFF);
      check("status write resp", 32'(r), 32'(RESP_SLVERR));
      rd(4'h8);
      check("unmapped resp", 32'(r), 32'(RESP_SLVERR));
      check("unmapped data", d, 32'h0000_0000);
      wr(CTRL_OFS, 32'hFFFF_FFFF);
      check("ctrl write resp", 32'(r), 32'(RESP_OKAY));
      rd(CTRL_OFS);
      check("ctrl readback", d, 32'h0000_031F);
      check("ctrl read resp", 32'(r), 32'(RESP_OKAY));
      $display("registers done");
      // disabled and reserved codes ignore edges and the enable bit
      foreach (off_codes[i]) begin
         c0 = start_count;
         ctrl(off_codes[i], 1'b0, 1'b1);
         repeat (3) begin
            queue2_external_trigger_pin <= ~queue2_external_trigger_pin;
            idle(10);
         end
         check("no start", 32'(start_count - c0), 32'h0);
      end
      $display("disabled modes done");
      // active edge starts, opposite edge does not; single scan needs enable again
      foreach (edge_codes[i]) begin
         m = edge_codes[i];
         ctrl(5'h00, 1'b0, 1'b0);
         queue2_external_trigger_pin <= m[0];
         idle(3);
         c0 = start_count;
         ctrl(m, 1'b0, 1'b1);
         idle(10);
         check("edge armed", 32'(start_count - c0), 32'h0);
         repeat (3) begin
            queue2_external_trigger_pin <= ~queue2_external_trigger_pin;
            idle(40);
         end
         check("edge starts", 32'(start_count - c0), m[4] ? 32'h2 : 32'h1);
      end
      $display("edge modes done");
      // timer interval of 2^n converter clocks, converter clock equal to sys_clk here
      foreach (tmr_codes[i]) begin
         m = tmr_codes[i];
         ctrl(5'h00, 1'b0, 1'b0);
         c0 = start_count;
         ctrl(m, 1'b0, 1'b1);
         idle((1 << (m[3:0] + 3)) - 10);
         check("timer early", 32'(start_count - c0), 32'h0);
         idle(20);
         check("timer first", 32'(start_count - c0), 32'h1);
         idle(1 << (m[3:0] + 3));
         check("timer second", 32'(start_count - c0), m[4] ? 32'h2 : 32'h1);
      end
      $display("timer modes done");
      // software single then continuous scans
      c0 = start_count;
      ctrl(5'h01, 1'b0, 1'b1);
      idle(40);
      check("sw single", 32'(start_count - c0), 32'h1);
      rd(STAT_OFS);
      check("enable cleared", 32'({d[12:8], d[3]}), 32'h02);
      ctrl(5'h11, 1'b0, 1'b1);
      idle(80);
      check("sw continuous", 32'(start_count - c0 > 3), 32'h1);
      ctrl(5'h11, 1'b0, 1'b0);
      idle(40);
      c0 = start_count;
      idle(60);
      check("sw stopped", 32'(start_count - c0), 32'h0);
      ctrl(5'h11, 1'b0, 1'b1);
      idle(5);
      ctrl(5'h00, 1'b0, 1'b0);
      idle(1);
      check("abort on disable", 32'(scan_active), 32'h0);
      $display("software modes done");
      // resume point: change during a scan waits for its end
      susp_en <= 1'b1;
      c0 = resume_count;
      ctrl(5'h01, 1'b0, 1'b1);
      ctrl(5'h01, 1'b1, 1'b0);
      idle(50);
      check("resume seen", 32'(resume_count - c0), 32'h1);
      check("resume held back", 32'(last_from_aborted), 32'h0);
      ctrl(5'h01, 1'b1, 1'b1);
      rd(STAT_OFS);
      check("status running", d, 32'h0000_010D);
      idle(50);
      check("resume aborted word", 32'(last_from_aborted), 32'h1);
      ctrl(5'h01, 1'b0, 1'b1);
      idle(50);
      check("resume first word", 32'(last_from_aborted), 32'h0);
      $display("resume done");
      give_verdict();
   end
endmodule
`default_nettype wire
